// ---- pdld_pkg.sv ----
// ==========================================================================
// Shared constants and types for the phase detector lock block.
// ==========================================================================
package pdld_pkg;

	// ======================================================================
	// Register map, byte addresses on the AXI4-Lite bus.
	// ======================================================================
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_DIV      = 8'h04;
	localparam logic [7:0] ADDR_STATUS   = 8'h08;
	localparam logic [7:0] ADDR_NRATIO   = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

	localparam logic [31:0] CTRL_RESET     = 32'h0000_0040;
	localparam logic [31:0] DIV_RESET      = 32'h0000_0001;
	localparam logic [1:0]  IRQ_MASK_RESET = 2'h0;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;

	// ======================================================================
	// Interrupt status bit positions.
	// ======================================================================
	localparam int IRQ_LOCK_GAINED = 0;
	localparam int IRQ_LOCK_LOST   = 1;

	// ======================================================================
	// Pin multiplexer codes.
	// ======================================================================
	localparam logic [1:0] PIN_SEL_FLAG    = 2'h0;
	localparam logic [1:0] PIN_SEL_PULSE_N = 2'h1;
	localparam logic [1:0] PIN_SEL_PULSE_P = 2'h2;
	localparam logic [1:0] PIN_SEL_LOW     = 2'h3;
	localparam logic [1:0] MON_SEL_LOW     = 2'h0;
	localparam logic [1:0] MON_SEL_FLAG    = 2'h1;
	localparam logic [1:0] MON_SEL_FLAG_N  = 2'h2;
	localparam logic [1:0] MON_SEL_PULSE   = 2'h3;

	// ======================================================================
	// Lock window timing, in aclk cycles of 25 ns.
	// ======================================================================
	localparam int         DLY_SPAN_NS   = 1;
	localparam logic [7:0] LOCK_THR_BASE [4] = '{8'h01, 8'h02, 8'h03, 8'h04};
	localparam logic [7:0] LOCK_RUN_LEN  [4] = '{8'h05, 8'h10, 8'h40, 8'hFF};

	// ======================================================================
	// Register layouts.
	// ======================================================================
	typedef struct packed {
		logic [12:0] spare;
		logic [1:0]  mon_sel;
		logic [1:0]  status_sel;
		logic [1:0]  pin_sel;
		logic [2:0]  fb_dly;
		logic [2:0]  ref_dly;
		logic        cnt_reset;
		logic [1:0]  run_sel;
		logic        lock_disable;
		logic        window_wide;
		logic [1:0]  antibacklash;
	} pdld_ctrl_s;

	typedef struct packed {
		logic [9:0]  spare;
		logic [12:0] main_cnt;
		logic [5:0]  swallow_cnt;
		logic [2:0]  presc_mode;
	} pdld_div_s;

	typedef enum logic [2:0] {
		PH_IDLE     = 3'b001,
		PH_WAIT_FB  = 3'b010,
		PH_WAIT_REF = 3'b100
	} pdld_phase_e;

endpackage : pdld_pkg

// ---- pdld_delay_line.sv ----
`timescale 1ns/100ps
// ==========================================================================
// Programmable delay: output follows input after code plus one cycles.
// ==========================================================================
module pdld_delay_line #(
	parameter int DEPTH = 8
) (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic [2:0] code,
	input  wire logic       din,
	output logic            dout
);

	logic [DEPTH-1:0] stage_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			stage_q[0] <= 1'b0;
		else
			stage_q[0] <= din;
	end

	genvar gi;
	generate
		for (gi = 1; gi < DEPTH; gi++)
		begin : g_stage
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
					stage_q[gi] <= 1'b0;
				else
					stage_q[gi] <= stage_q[gi-1];
			end
		end
	endgenerate

	assign dout = stage_q[code];

	chk_delay_zero_step: assert property (@(posedge aclk) disable iff (!aresetn)
		(code == 3'h0 && $past(code) == 3'h0) |-> dout == $past(din))
		else $error("Delay code zero does not give one cycle.");

endmodule : pdld_delay_line

// ---- pdld_top.sv ----
// Our own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps
// Notes on behaviour
// - Both paths get a 3-bit delay cell.
// - Lock only when edge spacing at or below threshold.
// - Unlock threshold wider than lock threshold.
// - Lock needs programmable run of good cycles.
// - One cycle beyond unlock threshold drops lock.
// - Windows depend on window bit and antibacklash.
// - Lock result muxed onto three output pins.
// - Lock pin offers low and high pulse outputs.
// - Main counter one bypasses counters; ratio is prescaler.
module pdld_top (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        ref_div_in,
	input  wire logic        fb_div_in,
	output logic             lock_indicator_pin_o,
	output logic             lock_indicator_pin_oe,
	output logic             status_pin,
	output logic             reference_monitor_pin,
	output logic             irq
);

	// ======================================================================
	// Register file and AXI4-Lite slave.
	// ======================================================================
	pdld_pkg::pdld_ctrl_s ctrl_q;
	pdld_pkg::pdld_div_s  div_q;
	logic [1:0]           irq_stat_q;
	logic [1:0]           irq_mask_q;
	logic [1:0]           irq_set;
	logic                 aw_held_q;
	logic                 w_held_q;
	logic [7:0]           awaddr_q;
	logic [31:0]          wdata_q;
	logic [3:0]           wstrb_q;
	logic                 wr_go;
	logic [31:0]          rdata_d;
	logic                 rd_hit;
	logic [31:0]          status_word;
	logic [17:0]          n_ratio_q;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[8*i +: 8] = nw[8*i +: 8];
		return r;
	endfunction : merge

	assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_go         = aw_held_q && w_held_q && !s_axi_bvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			awaddr_q  <= 8'h00;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			else if (wr_go)
				aw_held_q <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			else if (wr_go)
				w_held_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= pdld_pkg::RESP_OKAY;
		end
		else if (wr_go)
		begin
			s_axi_bvalid <= 1'b1;
			case (awaddr_q[7:2])
				pdld_pkg::ADDR_CTRL[7:2], pdld_pkg::ADDR_DIV[7:2], pdld_pkg::ADDR_IRQ_STAT[7:2],
				pdld_pkg::ADDR_IRQ_MASK[7:2], pdld_pkg::ADDR_STATUS[7:2], pdld_pkg::ADDR_NRATIO[7:2]:
					s_axi_bresp <= pdld_pkg::RESP_OKAY;
				default:
					s_axi_bresp <= pdld_pkg::RESP_SLVERR;
			endcase
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_q     <= pdld_pkg::CTRL_RESET;
			div_q      <= pdld_pkg::DIV_RESET;
			irq_mask_q <= pdld_pkg::IRQ_MASK_RESET;
		end
		else if (wr_go)
		begin
			if (awaddr_q[7:2] == pdld_pkg::ADDR_CTRL[7:2])
				ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q);
			if (awaddr_q[7:2] == pdld_pkg::ADDR_DIV[7:2])
				div_q <= merge(div_q, wdata_q, wstrb_q);
			if (awaddr_q[7:2] == pdld_pkg::ADDR_IRQ_MASK[7:2] && wstrb_q[0])
				irq_mask_q <= wdata_q[1:0];
		end
	end

	// Hardware set wins over a write-one clear in the same cycle.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			irq_stat_q <= 2'h0;
		else if (wr_go && awaddr_q[7:2] == pdld_pkg::ADDR_IRQ_STAT[7:2] && wstrb_q[0])
			irq_stat_q <= (irq_stat_q & ~wdata_q[1:0]) | irq_set;
		else
			irq_stat_q <= irq_stat_q | irq_set;
	end

	assign irq = |(irq_stat_q & irq_mask_q);

	always_comb
	begin
		rd_hit  = 1'b1;
		rdata_d = 32'h0000_0000;
		case (s_axi_araddr[7:2])
			pdld_pkg::ADDR_CTRL[7:2]:     rdata_d = ctrl_q;
			pdld_pkg::ADDR_DIV[7:2]:      rdata_d = div_q;
			pdld_pkg::ADDR_STATUS[7:2]:   rdata_d = status_word;
			pdld_pkg::ADDR_NRATIO[7:2]:   rdata_d = {14'h0000, n_ratio_q};
			pdld_pkg::ADDR_IRQ_STAT[7:2]: rdata_d = {30'h0000_0000, irq_stat_q};
			pdld_pkg::ADDR_IRQ_MASK[7:2]: rdata_d = {30'h0000_0000, irq_mask_q};
			default:                      rd_hit  = 1'b0;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= pdld_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rdata_d;
			s_axi_rresp  <= rd_hit ? pdld_pkg::RESP_OKAY : pdld_pkg::RESP_SLVERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ======================================================================
	// Feedback divide ratio and legality of the divider setting.
	// ======================================================================
	logic [5:0] presc_val;
	logic       dual_ratio_mode;
	logic       div_illegal;

	always_comb
	begin
		dual_ratio_mode = div_q.presc_mode >= 3'h3;
		case (div_q.presc_mode)
			3'h0:    presc_val = 6'h01;
			3'h1:    presc_val = 6'h02;
			3'h2:    presc_val = 6'h03;
			3'h3:    presc_val = 6'h02;
			3'h4:    presc_val = 6'h04;
			3'h5:    presc_val = 6'h08;
			3'h6:    presc_val = 6'h10;
			default: presc_val = 6'h20;
		endcase
	end

	assign div_illegal = dual_ratio_mode && ({7'h00, div_q.swallow_cnt} > div_q.main_cnt);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			n_ratio_q <= 18'h0_0001;
		else if (div_q.main_cnt == 13'h0001)
			n_ratio_q <= {12'h000, presc_val};
		else if (dual_ratio_mode)
			n_ratio_q <= 18'({12'h000, presc_val} * {5'h00, div_q.main_cnt}) + {12'h000, div_q.swallow_cnt};
		else
			n_ratio_q <= 18'({12'h000, presc_val} * {5'h00, div_q.main_cnt});
	end

	// ======================================================================
	// Pin synchronisers, delay cells and rising edge detection.
	// ======================================================================
	logic [1:0] ref_sync_q;
	logic [1:0] fb_sync_q;
	logic       ref_dly;
	logic       fb_dly;
	logic       ref_prev_q;
	logic       fb_prev_q;
	logic       ref_edge;
	logic       fb_edge;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ref_sync_q <= 2'h0;
			fb_sync_q  <= 2'h0;
			ref_prev_q <= 1'b0;
			fb_prev_q  <= 1'b0;
		end
		else
		begin
			ref_sync_q <= {ref_sync_q[0], ref_div_in};
			fb_sync_q  <= {fb_sync_q[0], fb_div_in};
			ref_prev_q <= ref_dly;
			fb_prev_q  <= fb_dly;
		end
	end

	pdld_delay_line #(.DEPTH(8)) u_ref_dly (
		.aclk    (aclk),
		.aresetn (aresetn),
		.code    (ctrl_q.ref_dly),
		.din     (ref_sync_q[1]),
		.dout    (ref_dly)
	);

	pdld_delay_line #(.DEPTH(8)) u_fb_dly (
		.aclk    (aclk),
		.aresetn (aresetn),
		.code    (ctrl_q.fb_dly),
		.din     (fb_sync_q[1]),
		.dout    (fb_dly)
	);

	assign ref_edge = ref_dly && !ref_prev_q;
	assign fb_edge  = fb_dly && !fb_prev_q;

	// ======================================================================
	// Edge spacing measurement against the lock and unlock windows.
	// ======================================================================
	pdld_pkg::pdld_phase_e ph_q;
	logic [7:0]            spacing_q;
	logic [7:0]            lock_thr;
	logic [7:0]            unlock_thr;
	logic                  eval_valid;
	logic [7:0]            eval_spacing;
	logic                  hold;

	// Wide window doubles the lock window; unlock is always twice lock.
	always_comb
	begin
		lock_thr   = pdld_pkg::LOCK_THR_BASE[ctrl_q.antibacklash] << ctrl_q.window_wide;
		unlock_thr = lock_thr << 1;
	end

	assign hold = ctrl_q.cnt_reset || ctrl_q.lock_disable;

	always_ff @(posedge aclk)
	begin
		if (!aresetn || hold)
		begin
			ph_q         <= pdld_pkg::PH_IDLE;
			spacing_q    <= 8'h00;
			eval_valid   <= 1'b0;
			eval_spacing <= 8'h00;
		end
		else
		begin
			eval_valid <= 1'b0;
			case (ph_q)
				pdld_pkg::PH_IDLE:
				begin
					spacing_q <= 8'h01;
					if (ref_edge && fb_edge)
					begin
						eval_valid   <= 1'b1;
						eval_spacing <= 8'h00;
					end
					else if (ref_edge)
						ph_q <= pdld_pkg::PH_WAIT_FB;
					else if (fb_edge)
						ph_q <= pdld_pkg::PH_WAIT_REF;
				end
				pdld_pkg::PH_WAIT_FB, pdld_pkg::PH_WAIT_REF:
				begin
					// A far edge missing past the unlock window counts as beyond it.
					if ((ph_q == pdld_pkg::PH_WAIT_FB ? fb_edge : ref_edge) || spacing_q > unlock_thr)
					begin
						eval_valid   <= 1'b1;
						eval_spacing <= spacing_q;
						ph_q         <= pdld_pkg::PH_IDLE;
					end
					else
						spacing_q <= spacing_q + 8'h01;
				end
				default:
					ph_q <= pdld_pkg::PH_IDLE;
			endcase
		end
	end

	// ======================================================================
	// Lock decision with hysteresis.
	// ======================================================================
	logic       edge_window_lock_flag_q;
	logic [7:0] run_q;
	logic       eval_good;
	logic       eval_bad;

	assign eval_good = eval_spacing <= lock_thr;
	assign eval_bad  = eval_spacing > unlock_thr;

	always_ff @(posedge aclk)
	begin
		if (!aresetn || hold)
		begin
			edge_window_lock_flag_q <= 1'b0;
			run_q                   <= 8'h00;
		end
		else if (eval_valid)
		begin
			if (eval_bad)
			begin
				edge_window_lock_flag_q <= 1'b0;
				run_q                   <= 8'h00;
			end
			else if (eval_good)
			begin
				if (run_q != 8'hFF)
					run_q <= run_q + 8'h01;
				if (run_q + 8'h01 >= pdld_pkg::LOCK_RUN_LEN[ctrl_q.run_sel])
					edge_window_lock_flag_q <= 1'b1;
			end
			else
				run_q <= 8'h00;
		end
	end

	assign irq_set[pdld_pkg::IRQ_LOCK_GAINED] = eval_valid && !eval_bad && eval_good && !hold &&
		!edge_window_lock_flag_q && (run_q + 8'h01 >= pdld_pkg::LOCK_RUN_LEN[ctrl_q.run_sel]);
	assign irq_set[pdld_pkg::IRQ_LOCK_LOST] = eval_valid && eval_bad && !hold && edge_window_lock_flag_q;

	assign status_word = {12'h000, div_illegal, lock_thr, run_q, 1'b0, ph_q != pdld_pkg::PH_IDLE,
		edge_window_lock_flag_q};

	// ======================================================================
	// Output pin multiplexers.
	// ======================================================================
	logic phase_err;
	logic pulse_lock_output;

	assign phase_err         = ph_q != pdld_pkg::PH_IDLE;
	assign pulse_lock_output = phase_err;

	function automatic logic mon_mux(input logic [1:0] sel, input logic lk, input logic pl);
		case (sel)
			pdld_pkg::MON_SEL_FLAG:   return lk;
			pdld_pkg::MON_SEL_FLAG_N: return !lk;
			pdld_pkg::MON_SEL_PULSE:  return pl;
			default:                  return 1'b0;
		endcase
	endfunction : mon_mux

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			lock_indicator_pin_o  <= 1'b0;
			lock_indicator_pin_oe <= 1'b1;
			status_pin            <= 1'b0;
			reference_monitor_pin <= 1'b0;
		end
		else
		begin
			status_pin            <= mon_mux(ctrl_q.status_sel, edge_window_lock_flag_q, pulse_lock_output);
			reference_monitor_pin <= mon_mux(ctrl_q.mon_sel, edge_window_lock_flag_q, pulse_lock_output);
			case (ctrl_q.pin_sel)
				pdld_pkg::PIN_SEL_FLAG:
				begin
					lock_indicator_pin_o  <= edge_window_lock_flag_q;
					lock_indicator_pin_oe <= 1'b1;
				end
				pdld_pkg::PIN_SEL_PULSE_N:
				begin
					lock_indicator_pin_o  <= 1'b0;
					lock_indicator_pin_oe <= pulse_lock_output;
				end
				pdld_pkg::PIN_SEL_PULSE_P:
				begin
					lock_indicator_pin_o  <= 1'b1;
					lock_indicator_pin_oe <= pulse_lock_output;
				end
				default:
				begin
					lock_indicator_pin_o  <= 1'b0;
					lock_indicator_pin_oe <= 1'b1;
				end
			endcase
		end
	end

	// ======================================================================
	// Checks.
	// ======================================================================
	chk_lock_needs_good: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(edge_window_lock_flag_q) |-> $past(eval_valid && eval_good && !eval_bad))
		else $error("Lock rose without a good cycle.");
	chk_bad_drops_lock: assert property (@(posedge aclk) disable iff (!aresetn)
		(eval_valid && eval_bad) |=> !edge_window_lock_flag_q && run_q == 8'h00)
		else $error("Bad cycle did not drop lock.");
	chk_hold_clears: assert property (@(posedge aclk) disable iff (!aresetn)
		hold |=> !edge_window_lock_flag_q && run_q == 8'h00)
		else $error("Counter hold did not clear lock.");
	chk_window_order: assert property (@(posedge aclk) disable iff (!aresetn)
		unlock_thr > lock_thr)
		else $error("Unlock window not wider than lock window.");
	chk_window_wide: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl_q.window_wide |-> lock_thr == {pdld_pkg::LOCK_THR_BASE[ctrl_q.antibacklash][6:0], 1'b0})
		else $error("Wide window select not applied.");
	chk_lock_spacing: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(edge_window_lock_flag_q) |-> $past(eval_spacing) <= $past(lock_thr))
		else $error("Lock taken on wide spacing.");
	chk_bypass_ratio: assert property (@(posedge aclk) disable iff (!aresetn)
		(div_q.main_cnt == 13'h0001 && $stable(div_q)) |=> n_ratio_q == {12'h000, $past(presc_val)})
		else $error("Bypass ratio differs from prescaler.");
	chk_pin_mux_flag: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl_q.pin_sel == pdld_pkg::PIN_SEL_FLAG |=> lock_indicator_pin_o == $past(edge_window_lock_flag_q))
		else $error("Lock pin does not follow the lock flag.");
	chk_pulse_n_pin: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl_q.pin_sel == pdld_pkg::PIN_SEL_PULSE_N |=> !lock_indicator_pin_o && lock_indicator_pin_oe == $past(phase_err))
		else $error("Pull-low pulse output wrong.");

endmodule : pdld_top

// ---- pdld_edge_model.sv ----
`timescale 1ns/100ps
// ==========================================================================
// Divider edge source and the wire seen on the lock pin.
// ==========================================================================
module pdld_edge_model (
	input  wire logic aclk,
	input  var int    period,
	input  var int    offset,
	input  wire logic pull_up,
	input  wire logic pin_o,
	input  wire logic pin_oe,
	output logic      ref_o,
	output logic      fb_o,
	output logic      pin_wire
);
	int cnt = 0;
	int off_q = 0;

	// The period handed in is always longer than the widest unlock window.
	// A new offset waits for the end of a period, so no feedback edge is doubled.
	always @(posedge aclk)
	begin
		cnt <= (cnt + 1) % period;
		if (cnt == period - 1)
			off_q <= offset;
		ref_o <= cnt < period / 2;
		fb_o <= ((cnt - off_q + period) % period) < period / 2;
	end

	// A released pin rests at the level of its external resistor.
	assign pin_wire = pin_oe ? pin_o : pull_up;
endmodule : pdld_edge_model

// ---- tb_pdld_top.sv ----
`timescale 1ns/100ps
module tb_pdld_top;
	typedef struct packed {
		logic [7:0]  wa;
		logic [31:0] wd;
		logic [1:0]  br;
		logic [7:0]  ra;
		logic [31:0] mk;
		logic [31:0] rx;
		logic [1:0]  rr;
	} pdld_row_s;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_wready;
	logic [1:0]  s_axi_bresp;
	logic        s_axi_bvalid;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0]  s_axi_rresp;
	logic        s_axi_rvalid;
	logic        ref_div_in;
	logic        fb_div_in;
	logic        pin_o;
	logic        pin_oe;
	logic        status_pin;
	logic        mon;
	logic        irq;
	logic        pin_wire;
	logic        pull_up = 1'b1;
	int          offset = 0;
	int          fail_count = 0;
	int          n_checks = 0;
	logic [1:0]  r;
	logic [31:0] d;
	int          k;
	pdld_row_s   rows [9] = '{
		'{8'h04, 32'h0000_0201, 2'h0, 8'h0C, 32'h0003_FFFF, 32'h0000_0002, 2'h0},
		'{8'h04, 32'h0000_0207, 2'h0, 8'h0C, 32'h0003_FFFF, 32'h0000_0020, 2'h0},
		'{8'h04, 32'h0000_060B, 2'h0, 8'h0C, 32'h0003_FFFF, 32'h0000_0007, 2'h0},
		'{8'h04, 32'h0000_0E00, 2'h0, 8'h0C, 32'h0003_FFFF, 32'h0000_0007, 2'h0},
		'{8'h04, 32'h0000_060C, 2'h0, 8'h0C, 32'h0003_FFFF, 32'h0000_000D, 2'h0},
		'{8'h04, 32'h0000_082A, 2'h0, 8'h0C, 32'h0003_FFFF, 32'h0000_000C, 2'h0},
		'{8'h04, 32'h0000_062B, 2'h0, 8'h08, 32'h0008_0000, 32'h0008_0000, 2'h0},
		'{8'h18, 32'h0000_0001, 2'h2, 8'h18, 32'hFFFF_FFFF, 32'h0000_0000, 2'h2},
		'{8'h14, 32'h0000_0003, 2'h0, 8'h14, 32'h0000_0003, 32'h0000_0003, 2'h0}
	};

	pdld_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(1'b1), .ref_div_in(ref_div_in), .fb_div_in(fb_div_in),
		.lock_indicator_pin_o(pin_o), .lock_indicator_pin_oe(pin_oe), .status_pin(status_pin),
		.reference_monitor_pin(mon), .irq(irq));

	pdld_edge_model peer (.aclk(aclk), .period(20), .offset(offset), .pull_up(pull_up),
		.pin_o(pin_o), .pin_oe(pin_oe), .ref_o(ref_div_in), .fb_o(fb_div_in), .pin_wire(pin_wire));

	initial
	begin
		forever #12.5 aclk = ~aclk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk

	// Write and read responses are always accepted, so each answer stands one cycle.
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rsp);
		bit ta;
		bit tw;
		bit tb;
		int n;
		@(posedge aclk);
		tb = 0;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!tb && n < 50)
		begin
			@(negedge aclk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bvalid === 1'b1;
			rsp = s_axi_bresp;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			n++;
		end
		chk({31'd0, tb}, 32'h0000_0001, "write answer");
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rsp);
		bit ta;
		bit tr;
		int n;
		@(posedge aclk);
		tr = 0;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		while (!tr && n < 50)
		begin
			@(negedge aclk);
			ta = s_axi_arvalid && s_axi_arready;
			tr = s_axi_rvalid === 1'b1;
			v = s_axi_rdata;
			rsp = s_axi_rresp;
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 1'b0;
			n++;
		end
		chk({31'd0, tr}, 32'h0000_0001, "read answer");
	endtask : rd

	task automatic wait_mon(input logic v, input int n, input string m);
		int i;
		i = 0;
		do
		begin
			@(negedge aclk);
			i++;
		end
		while (mon !== v && i < n);
		chk({31'd0, mon}, {31'd0, v}, m);
	endtask : wait_mon

	task automatic count_wire(input logic v, output int c);
		c = 0;
		repeat (100)
		begin
			@(negedge aclk);
			if (pin_wire === v) c++;
		end
	endtask : count_wire

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test

	initial
	begin
		repeat (20000) @(posedge aclk);
		fail_count++;
		end_of_test();
	end

	initial
	begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		foreach (rows[i])
		begin
			wr(rows[i].wa, rows[i].wd, r);
			chk({30'd0, r}, {30'd0, rows[i].br}, "bresp");
			rd(rows[i].ra, d, r);
			chk(d & rows[i].mk, rows[i].rx, "rdata");
			chk({30'd0, r}, {30'd0, rows[i].rr}, "rresp");
		end
		$display("test table done");
		wr(8'h00, 32'h0002_0000, r);
		repeat (60) @(negedge aclk);
		chk({31'd0, mon}, 32'h0000_0000, "lock too early");
		wait_mon(1'b1, 300, "lock gained");
		chk({30'd0, pin_oe, pin_o}, 32'h0000_0003, "lock pin level");
		rd(8'h10, d, r);
		chk(d & 32'h0000_0003, 32'h0000_0001, "gained event");
		chk({31'd0, irq}, 32'h0000_0001, "irq raised");
		wr(8'h10, 32'h0000_0001, r);
		chk({31'd0, irq}, 32'h0000_0000, "irq cleared");
		offset <= 2;
		count_wire(1'b1, k);
		chk(k, 100, "lock held between windows");
		offset <= 3;
		wait_mon(1'b0, 80, "lock lost");
		rd(8'h10, d, r);
		chk(d & 32'h0000_0003, 32'h0000_0002, "lost event");
		wr(8'h14, 32'h0000_0001, r);
		chk({31'd0, irq}, 32'h0000_0000, "lost event masked");
		wr(8'h10, 32'h0000_0003, r);
		$display("test lock done");
		wr(8'h00, 32'h0002_0180, r);
		wait_mon(1'b1, 300, "delay aligns edges");
		wr(8'h00, 32'h0002_0044, r);
		wait_mon(1'b0, 10, "hold clears lock");
		offset <= 2;
		wr(8'h00, 32'h0002_8004, r);
		wait_mon(1'b1, 300, "wide window locks");
		chk({31'd0, status_pin}, 32'h0000_0001, "status pin lock");
		wr(8'h00, 32'h0002_2004, r);
		count_wire(1'b0, k);
		chk({31'd0, k > 0 && k < 50}, 32'h0000_0001, "low pulses");
		pull_up <= 1'b0;
		wr(8'h00, 32'h0002_4004, r);
		count_wire(1'b1, k);
		chk({31'd0, k > 0 && k < 50}, 32'h0000_0001, "high pulses");
		wr(8'h00, 32'h0003_000C, r);
		wait_mon(1'b0, 10, "disable clears lock");
		chk({31'd0, status_pin}, 32'h0000_0001, "status pin inverted");
		rd(8'h08, d, r);
		chk(d & 32'h0000_07F9, 32'h0000_0000, "run count cleared");
		$display("test window done");
		aresetn <= 1'b0;
		repeat (20) @(posedge aclk);
		chk({28'd0, mon, pin_oe, pin_o, irq}, 32'h0000_0004, "pins in reset");
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(8'h00, d, r);
		chk(d, 32'h0000_0040, "ctrl reset");
		rd(8'h04, d, r);
		chk(d, 32'h0000_0001, "div reset");
		rd(8'h14, d, r);
		chk(d, 32'h0000_0000, "mask reset");
		$display("test reset done");
		end_of_test();
	end
endmodule : tb_pdld_top
